// ===== verilog/sep_pkg.sv
// constants and types shared by the serial eeprom command interface
// What this block does
// - sample input on rise, drive output after fall
// - active only with select low, suspend released
// - all fields travel most significant bit first
// - decode set, clear write enable, status read
// - status write opcode takes one data byte
// - array opcodes carry ninth address bit three
// - output floats while bits are shifted in
// - read output driven from falls, input ignored
// - suspend changes only take effect clock low
// - suspended: clock ignored, position kept, resume
// - suspend low always floats the output
// - accept clock idle low or high
// - read: opcode, address, then data shifted
// - read address increments and wraps around
// - status bits three, two are protect level
// - write enable latch gates every write
// - status bit zero reports program busy
// - while busy only status read is accepted
// - status byte shifted out bit seven first
// - protect pin low refuses all writes
// - protect pin spares a started program
// - protect level selects protected array range
// - write enable latch clear after reset
// - bad opcode: ignore until next select
package sep_pkg;
  localparam logic [7:0] SET_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_ENABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_OP_MASK = 8'hF7;
  localparam logic [7:0] ARRAY_READ_OP = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_OP = 8'h02;
  localparam int ADDR_MSB_POS = 3;
  localparam int BUSY_POS = 0;
  localparam int WEL_POS = 1;
  localparam int PROTECT_LEVEL_LO_POS = 2;
  localparam int PROTECT_LEVEL_HI_POS = 3;
  localparam logic [3:0] STATUS_UPPER = 4'h0;
  localparam logic [1:0] PROTECT_RESET = 2'h0;
  localparam logic WEL_RESET = 1'h0;
  localparam logic [8:0] PROT_L1_BASE = 9'h180;
  localparam logic [8:0] PROT_L2_BASE = 9'h100;
  localparam logic [8:0] LAST_ADDR = 9'h1FF;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_BYTES = 4;
  localparam int WRITE_TIME_MS = 15;
  localparam int CLK_MHZ = 250;
  localparam int PROG_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CNT_W = 22;

  // gray order along the array read path: opcode, address, output
  typedef enum logic [2:0] {
    ST_OPC = 3'h0,
    ST_ADDR = 3'h1,
    ST_OUT = 3'h3,
    ST_WDATA = 3'h2,
    ST_SRDATA = 3'h6,
    ST_DEAD = 3'h7
  } sep_state_t;
endpackage

// ===== verilog/sep_sync.sv
// two flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sep_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          meta[g] <= RST_VAL[g];
          sync_out[g] <= RST_VAL[g];
        end else begin
          meta[g] <= async_in[g];
          sync_out[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule

// ===== verilog/sep_prog_timer.sv
// self timed program cycle: busy for a fixed number of cycles
`timescale 1ns/1ps
module sep_prog_timer #(
  parameter int CYCLES = sep_pkg::PROG_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  output logic busy_out
);
  typedef struct packed {
    logic busy;
    logic [sep_pkg::PROG_CNT_W-1:0] cnt;
  } sep_tmr_t;
  sep_tmr_t st;
  sep_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (start_in && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.cnt = sep_pkg::PROG_CNT_W'(CYCLES - 1);
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = st.busy;
endmodule

// ===== verilog/sep_core.sv
// serial eeprom command interface, array and status register
`timescale 1ns/1ps
module sep_core #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out
);
  typedef struct packed {
    sep_pkg::sep_state_t state;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [8:0] addr;
    logic wel;
    logic [1:0] bp;
    logic rd_array;
    logic rd_status;
    logic drv;
    logic [2:0] ocnt;
    logic [6:0] obyte;
    logic so;
    logic so_oe;
    logic hold_q;
    logic sck_d;
    logic cs_d;
    logic busy_d;
    logic [1:0] wptr;
    logic [3:0] pvalid;
    logic [31:0] pbuf;
  } sep_core_t;

  sep_core_t st;
  sep_core_t next_st;
  logic [7:0] mem [sep_pkg::MEM_DEPTH];

  logic cs_s;
  logic sck_s;
  logic si_s;
  logic hold_s;
  logic wp_s;
  logic busy;
  logic rise;
  logic fall;
  logic byte_done;
  logic commit;
  logic wr_commit;
  logic sr_commit;
  logic prog_start;
  logic page_prot;
  logic status_msb;
  logic [7:0] in_word;
  logic [7:0] status_byte;
  logic [7:0] mem_q;
  logic [3:0] page_hit;

  function automatic logic is_protected(input logic [1:0] lvl, input logic [8:0] a);
    logic r;
    r = 1'b0;
    case (lvl)
      2'h0: r = 1'b0;
      2'h1: r = (a >= sep_pkg::PROT_L1_BASE);
      2'h2: r = (a >= sep_pkg::PROT_L2_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  sep_sync #(
    .WIDTH(5),
    .RST_VAL(5'h17)
  ) u_sync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .async_in({cs_n_in, sck_in, si_in, hold_n_in, wp_n_in}),
    .sync_out({cs_s, sck_s, si_s, hold_s, wp_s})
  );

  sep_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .start_in(prog_start),
    .busy_out(busy)
  );

  // edges only count while selected and not suspended
  assign rise = !cs_s && !st.hold_q && sck_s && !st.sck_d;
  assign fall = !cs_s && !st.hold_q && !sck_s && st.sck_d;
  assign in_word = {st.shreg[6:0], si_s};
  assign byte_done = rise && (st.bitcnt == 3'h7);
  assign status_byte = {sep_pkg::STATUS_UPPER, st.bp, st.wel, busy};
  assign status_msb = status_byte[7];
  assign mem_q = mem[st.addr];
  assign commit = cs_s && !st.cs_d;

  genvar g;
  generate
    for (g = 0; g < sep_pkg::PAGE_BYTES; g++) begin : g_prot
      assign page_hit[g] = st.pvalid[g] && is_protected(st.bp, {st.addr[8:2], 2'(g)});
    end
  endgenerate
  assign page_prot = |page_hit;

  // the pin and latch are judged when the program would start
  assign wr_commit = commit && (st.state == sep_pkg::ST_WDATA) && (st.bitcnt == 3'h0)
    && (|st.pvalid) && st.wel && wp_s && !busy && !page_prot;
  assign sr_commit = commit && (st.state == sep_pkg::ST_SRDATA) && (st.bitcnt == 3'h0)
    && st.pvalid[0] && st.wel && wp_s && !busy;
  assign prog_start = wr_commit || sr_commit;

  always_comb begin
    next_st = st;
    next_st.sck_d = sck_s;
    next_st.cs_d = cs_s;
    next_st.busy_d = busy;
    // a suspend change seen with the clock high waits for the fall
    if (!sck_s) begin
      next_st.hold_q = !hold_s;
    end
    if (st.busy_d && !busy) begin
      next_st.wel = 1'b0;
    end
    if (sr_commit) begin
      next_st.bp = st.pbuf[sep_pkg::PROTECT_LEVEL_HI_POS:sep_pkg::PROTECT_LEVEL_LO_POS];
    end
    if (cs_s) begin
      next_st.state = sep_pkg::ST_OPC;
      next_st.bitcnt = 3'h0;
      next_st.drv = 1'b0;
      next_st.ocnt = 3'h0;
      next_st.hold_q = 1'b0;
      next_st.pvalid = 4'h0;
    end else begin
      if (rise && (st.state != sep_pkg::ST_OUT) && (st.state != sep_pkg::ST_DEAD)) begin
        next_st.shreg = in_word;
        next_st.bitcnt = st.bitcnt + 3'h1;
      end
      if (byte_done) begin
        case (st.state)
          sep_pkg::ST_OPC: begin
            if (busy && (in_word != sep_pkg::STATUS_READ_CMD)) begin
              next_st.state = sep_pkg::ST_DEAD;
            end else if (in_word == sep_pkg::SET_WRITE_ENABLE_CMD) begin
              next_st.wel = 1'b1;
              next_st.state = sep_pkg::ST_DEAD;
            end else if (in_word == sep_pkg::CLEAR_WRITE_ENABLE_CMD) begin
              next_st.wel = 1'b0;
              next_st.state = sep_pkg::ST_DEAD;
            end else if (in_word == sep_pkg::STATUS_READ_CMD) begin
              next_st.rd_status = 1'b1;
              next_st.state = sep_pkg::ST_OUT;
            end else if (in_word == sep_pkg::STATUS_WRITE_CMD) begin
              next_st.state = sep_pkg::ST_SRDATA;
            end else if ((in_word & sep_pkg::ARRAY_OP_MASK) == sep_pkg::ARRAY_READ_OP) begin
              next_st.addr[8] = in_word[sep_pkg::ADDR_MSB_POS];
              next_st.rd_array = 1'b1;
              next_st.rd_status = 1'b0;
              next_st.state = sep_pkg::ST_ADDR;
            end else if ((in_word & sep_pkg::ARRAY_OP_MASK) == sep_pkg::ARRAY_WRITE_OP) begin
              next_st.addr[8] = in_word[sep_pkg::ADDR_MSB_POS];
              next_st.rd_array = 1'b0;
              next_st.state = sep_pkg::ST_ADDR;
            end else begin
              next_st.state = sep_pkg::ST_DEAD;
            end
          end
          sep_pkg::ST_ADDR: begin
            next_st.addr[7:0] = in_word;
            next_st.wptr = in_word[1:0];
            next_st.rd_status = 1'b0;
            if (st.rd_array) begin
              next_st.state = sep_pkg::ST_OUT;
            end else begin
              next_st.state = sep_pkg::ST_WDATA;
            end
          end
          sep_pkg::ST_WDATA: begin
            // page counter wraps within four bytes
            next_st.pbuf[{st.wptr, 3'h0} +: 8] = in_word;
            next_st.pvalid[st.wptr] = 1'b1;
            next_st.wptr = st.wptr + 2'h1;
          end
          sep_pkg::ST_SRDATA: begin
            next_st.pbuf[7:0] = in_word;
            next_st.pvalid[0] = 1'b1;
          end
          default: begin
            next_st.state = st.state;
          end
        endcase
      end
      if (fall && (st.state == sep_pkg::ST_OUT)) begin
        next_st.drv = 1'b1;
        next_st.ocnt = st.ocnt + 3'h1;
        if (st.ocnt == 3'h0) begin
          if (st.rd_status) begin
            // status is not latched: busy updates between repeats
            next_st.so = status_byte[7];
            next_st.obyte = status_byte[6:0];
          end else begin
            next_st.so = mem_q[7];
            next_st.obyte = mem_q[6:0];
            next_st.addr = st.addr + 9'h1;
          end
        end else begin
          next_st.so = st.obyte[6];
          next_st.obyte = {st.obyte[5:0], 1'b0};
        end
      end
    end
    // output floats while input is shifted or suspend is low
    next_st.so_oe = next_st.drv && hold_s && !cs_s
      && (next_st.state == sep_pkg::ST_OUT);
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
      st.state <= sep_pkg::ST_OPC;
      st.wel <= sep_pkg::WEL_RESET;
      st.bp <= sep_pkg::PROTECT_RESET;
      st.cs_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // array has no reset; only a committed page changes it
  always_ff @(posedge clock_in) begin
    if (wr_commit) begin
      for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
        if (st.pvalid[i]) begin
          mem[{st.addr[8:2], 2'(i)}] <= st.pbuf[i*8 +: 8];
        end
      end
    end
  end

  assign so_out = st.so;
  assign so_oe_out = st.so_oe;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_stat_load;
    fall && (st.state == sep_pkg::ST_OUT) && (st.ocnt == 3'h0) && st.rd_status;
  endsequence

  sequence s_wrap_load;
    fall && (st.state == sep_pkg::ST_OUT) && (st.ocnt == 3'h0) && !st.rd_status
      && (st.addr == sep_pkg::LAST_ADDR);
  endsequence

  out_after_fall_a: assert property ($changed(so_out) |-> $past(fall))
    else $error("output changed without a clock fall");
  status_msb_first_a: assert property (s_stat_load |=> so_out == $past(status_msb))
    else $error("status byte did not start with bit seven");
  read_wrap_a: assert property (s_wrap_load |=> st.addr == 9'h000)
    else $error("read address did not wrap to zero");
  set_wel_a: assert property ((byte_done && (st.state == sep_pkg::ST_OPC) && !busy
    && (in_word == sep_pkg::SET_WRITE_ENABLE_CMD)) |=> st.wel)
    else $error("write enable latch not set");
  prog_needs_wel_a: assert property (prog_start |-> st.wel && !busy)
    else $error("program started without write enable");
  prog_needs_pin_a: assert property (prog_start |-> wp_s)
    else $error("program started with protect pin low");
  hold_floats_a: assert property (!hold_s |=> !so_oe_out)
    else $error("output driven while suspended");
  oe_only_out_a: assert property (so_oe_out |-> st.state == sep_pkg::ST_OUT && st.drv)
    else $error("output driven outside read phase");
  dead_stays_a: assert property ((st.state == sep_pkg::ST_DEAD) && !cs_s
    |=> (st.state == sep_pkg::ST_DEAD) && !so_oe_out)
    else $error("left ignore state while selected");
  deselect_abort_a: assert property (cs_s |=> (st.state == sep_pkg::ST_OPC)
    && (st.bitcnt == 3'h0))
    else $error("deselect did not reset decoder");
  hold_keeps_a: assert property (st.hold_q && !cs_s |=> $stable(st.bitcnt)
    && $stable(st.addr))
    else $error("position moved while suspended");
  hold_change_a: assert property ($changed(st.hold_q) |-> $past(!sck_s))
    else $error("suspend changed with clock high");

  // array loads move the address on; status loads do not
  sequence s_arr_load;
    fall && (st.state == sep_pkg::ST_OUT) && (st.ocnt == 3'h0) && !st.rd_status;
  endsequence

  sequence s_next_bit;
    fall && (st.state == sep_pkg::ST_OUT) && (st.ocnt != 3'h0);
  endsequence

  shift_in_a: assert property (rise && (st.state != sep_pkg::ST_OUT)
    && (st.state != sep_pkg::ST_DEAD) |=> st.shreg == $past(in_word))
    else $error("input bit not shifted in");
  out_ignores_in_a: assert property (rise && (st.state == sep_pkg::ST_OUT)
    |=> $stable(st.shreg))
    else $error("input taken while driving output");
  next_bit_a: assert property (s_next_bit |=> so_out == $past(st.obyte[6]))
    else $error("output bit order broken");
  read_incr_a: assert property (s_arr_load |=> st.addr == $past(st.addr) + 9'h1)
    else $error("read address did not advance");
  stat_rest_a: assert property (s_stat_load |=> st.obyte == $past(status_byte[6:0]))
    else $error("status byte tail not loaded");
  clear_wel_a: assert property ((byte_done && (st.state == sep_pkg::ST_OPC) && !busy
    && (in_word == sep_pkg::CLEAR_WRITE_ENABLE_CMD)) |=> !st.wel)
    else $error("write enable latch not cleared");
  busy_refuse_a: assert property ((byte_done && (st.state == sep_pkg::ST_OPC) && busy
    && (in_word != sep_pkg::STATUS_READ_CMD)) |=> st.state == sep_pkg::ST_DEAD)
    else $error("command taken while busy");
  addr_msb_a: assert property ((byte_done && (st.state == sep_pkg::ST_OPC) && !busy
    && ((in_word & sep_pkg::ARRAY_OP_MASK) == sep_pkg::ARRAY_READ_OP))
    |=> st.addr[8] == $past(in_word[sep_pkg::ADDR_MSB_POS]))
    else $error("ninth address bit not taken from opcode");
  sr_write_a: assert property (sr_commit
    |=> st.bp == $past(st.pbuf[sep_pkg::PROTECT_LEVEL_HI_POS:sep_pkg::PROTECT_LEVEL_LO_POS]))
    else $error("protect level not written");
  wel_drop_a: assert property (st.busy_d && !busy && !byte_done |=> !st.wel)
    else $error("write enable kept after program");
  // first page byte is always loaded, so it must be writable
  page_guard_a: assert property (wr_commit |-> !is_protected(st.bp, st.addr))
    else $error("program started in protected range");
  cs_floats_a: assert property (cs_s |=> !so_oe_out)
    else $error("output driven while deselected");
endmodule

// ===== testbench/sep_master.sv
// bus master model driving the eeprom select, clock, data and suspend pins
`timescale 1ns/1ps
module sep_master (
  input wire logic clock_in,
  input wire logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_n_out
);
  logic inbound;
  logic mode3;
  initial begin
    cs_n_out = 1'h1;
    sck_out = 1'h0;
    si_out = 1'h0;
    hold_n_out = 1'h1;
    inbound = 1'h0;
    mode3 = 1'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // clock sits at its idle level before select falls
  task automatic start(input logic m3);
    mode3 = m3;
    sck_out = m3;
    wait_clk(2);
    cs_n_out = 1'h0;
    wait_clk(4);
  endtask
  // long low phase absorbs the device's pin sync latency before sampling
  task automatic shift(input logic [7:0] d, input int nb, input logic inb, input int hold_at,
                       output logic [7:0] q);
    inbound = inb;
    q = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_out = 1'h0;
      si_out = d[i];
      if (i == hold_at) begin
        wait_clk(4);
        hold_n_out = 1'h0;
        // pin activity while suspended must be ignored
        repeat (4) begin
          wait_clk(3);
          sck_out = ~sck_out;
          si_out = ~si_out;
        end
        wait_clk(2);
        hold_n_out = 1'h1;
        wait_clk(4);
      end
      wait_clk(6);
      q[i] = so_in;
      sck_out = 1'h1;
      wait_clk(2);
    end
    inbound = 1'h0;
  endtask
  // mode 0 ends with clock low so no extra rise is counted
  task automatic stop();
    if (!mode3) sck_out = 1'h0;
    wait_clk(4);
    cs_n_out = 1'h1;
    wait_clk(8);
  endtask
endmodule

// ===== testbench/sep_core_tb.sv
// self-checking bench for the serial eeprom command interface
`timescale 1ns/1ps
module sep_core_tb;
  logic clock_in;
  logic arst_n;
  logic wp_n;
  logic cs_n, sck, si, hold_n, so_out, so_oe_out, float_pat, so_line;
  logic [7:0] mem [512];
  logic [7:0] s;
  logic [1:0] bp;
  logic wel;
  logic [8:0] pa [4];
  int seed, n_errors, n_tests, hold_cnt, cs_cnt;
  sep_core #(.PROG_CYCLES(400)) DUT (
    .clock_in(clock_in),
    .arst_n_in(arst_n),
    .cs_n_in(cs_n),
    .sck_in(sck),
    .si_in(si),
    .hold_n_in(hold_n),
    .wp_n_in(wp_n),
    .so_out(so_out),
    .so_oe_out(so_oe_out)
  );
  sep_master m (
    .clock_in(clock_in),
    .so_in(so_line),
    .cs_n_out(cs_n),
    .sck_out(sck),
    .si_out(si),
    .hold_n_out(hold_n)
  );
  // a floating line must not look like stable data
  assign so_line = so_oe_out ? so_out : float_pat;
  initial clock_in = 1'h0;
  initial float_pat = 1'h0;
  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) float_pat <= ~float_pat;
  always @(negedge clock_in) begin
    hold_cnt <= hold_n ? 0 : hold_cnt + 1;
    cs_cnt <= cs_n ? cs_cnt + 1 : 0;
    if (hold_cnt > 4 || cs_cnt > 5 || m.inbound) chk("so_oe", {7'h0, so_oe_out}, 8'h00);
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic page_ok(logic [8:0] a, logic [1:0] lvl);
    return lvl == 2'h0 || (lvl == 2'h1 && a < 9'h180) || (lvl == 2'h2 && a < 9'h100);
  endfunction
  task automatic op_only(input logic [7:0] op);
    logic [7:0] q;
    m.start(1'h0);
    m.shift(op, 8, 1'h1, -1, q);
    m.stop();
  endtask
  task automatic status(output logic [7:0] st, input logic m3);
    logic [7:0] q;
    m.start(m3);
    m.shift(8'h05, 8, 1'h1, -1, q);
    m.shift(8'($random(seed)), 8, 1'h0, -1, st);
    m.stop();
  endtask
  task automatic wr(input logic [7:0] op, input logic [8:0] a, input int n, input logic [31:0] d);
    logic [7:0] q;
    logic ok;
    ok = wel && wp_n && (op == 8'h01 || page_ok(a, bp));
    m.start(1'h0);
    m.shift(op | {4'h0, a[8], 3'h0}, 8, 1'h1, -1, q);
    if (op != 8'h01) m.shift(a[7:0], 8, 1'h1, -1, q);
    for (int k = 0; k < n; k++) begin
      m.shift(d[31-8*k -: 8], 8, 1'h1, -1, q);
      if (ok && op != 8'h01) mem[{a[8:2], a[1:0] + k[1:0]}] = d[31-8*k -: 8];
    end
    m.stop();
    if (ok && op == 8'h01) bp = d[27:26];
    status(s, 1'h0);
    chk("busy_start", {7'h0, s[0]}, {7'h0, ok});
    if (ok) begin
      chk("busy_wel", s[1:0], 8'h03);
      for (int t = 0; t < 10 && s[0] === 1'h1; t++) status(s, 1'h0);
      if (s[0] !== 1'h0) begin
        n_errors++;
        conclude();
      end
      wel = 1'h0;
      chk("stat_done", s, {4'h0, bp, 2'h0});
    end
  endtask
  task automatic rd(input logic [8:0] a, input int n, input logic m3, input int hold_at);
    logic [7:0] q;
    m.start(m3);
    m.shift({4'h0, a[8], 3'h3}, 8, 1'h1, -1, q);
    m.shift(a[7:0], 8, 1'h1, -1, q);
    for (int k = 0; k < n; k++) begin
      m.shift(8'($random(seed)), 8, 1'h0, k == 1 ? hold_at : -1, q);
      chk("rd_data", q, mem[9'(a + k)]);
    end
    m.stop();
  endtask
  initial begin
    seed = 69396;
    n_errors = 0;
    n_tests = 0;
    hold_cnt = 0;
    cs_cnt = 0;
    arst_n = 1'h0;
    wp_n = 1'h1;
    bp = 2'h0;
    wel = 1'h0;
    pa = '{9'h1FC, 9'h000, 9'h17C, 9'h180};
    repeat (2) @(posedge clock_in);
    @(negedge clock_in) arst_n = 1'h1;
    status(s, 1'h0);
    chk("stat_rst", s, 8'h00);
    op_only(8'h06);
    status(s, 1'h1);
    chk("stat_set", s, 8'h02);
    op_only(8'h04);
    status(s, 1'h0);
    chk("stat_clr", s, 8'h00);
    wr(8'h02, 9'h000, 1, $random(seed));
    op_only(8'h06);
    wel = 1'h1;
    wp_n = 1'h0;
    wr(8'h02, 9'h000, 1, $random(seed));
    wp_n = 1'h1;
    for (int p = 0; p < 4; p++) begin
      op_only(8'h06);
      wel = 1'h1;
      wr(8'h02, pa[p], 4, $random(seed));
    end
    rd(9'h1FE, 6, 1'h1, -1);
    rd(9'h17C, 5, 1'h0, 3);
    op_only(8'h06);
    wel = 1'h1;
    wr(8'h01, 9'h000, 1, 32'h04000000);
    op_only(8'h06);
    wel = 1'h1;
    wr(8'h02, 9'h180, 4, $random(seed));
    rd(9'h180, 4, 1'h0, -1);
    op_only(8'h04);
    wel = 1'h0;
    m.start(1'h0);
    m.shift(8'hFF, 8, 1'h1, -1, s);
    m.shift(8'h03, 8, 1'h1, -1, s);
    m.stop();
    m.start(1'h0);
    m.shift(8'h05, 4, 1'h1, -1, s);
    m.stop();
    status(s, 1'h0);
    chk("stat_abort", s, {4'h0, bp, wel, 1'h0});
    conclude();
  end
endmodule
